// *** design/scf_defs.vh ***
`ifndef SCF_DEFS_VH
`define SCF_DEFS_VH
// register offsets
`define SCF_ADDR_DTRAIN 8'h82
`define SCF_ADDR_MARKER 8'h83
`define SCF_ADDR_BLACK 8'h84
`define SCF_ADDR_IMAGE 8'h85
`define SCF_ADDR_CRCIND 8'h86
`define SCF_ADDR_STRAIN 8'h87
`define SCF_ADDR_CTRL 8'h88
`define SCF_ADDR_STATUS 8'h89
// reset values
`define SCF_RST_DTRAIN 10'h3a6
`define SCF_RST_MARKER 7'h2a
`define SCF_RST_BLACK 10'h015
`define SCF_RST_IMAGE 10'h035
`define SCF_RST_CRCIND 10'h059
`define SCF_RST_STRAIN 10'h3a6
`define SCF_RST_CTRL 2'h0
// control field positions
`define SCF_CTL_MODE8 0
`define SCF_CTL_SEED 1
// sync word type codes
`define SCF_TYPE_FOPEN 3'h5
`define SCF_TYPE_FCLOSE 3'h6
`define SCF_TYPE_LOPEN 3'h1
`define SCF_TYPE_LCLOSE 3'h2
// stream entry kinds
`define SCF_KIND_BLACK 2'h0
`define SCF_KIND_IMAGE 2'h1
`define SCF_KIND_OPEN 2'h2
`define SCF_KIND_CLOSE 2'h3
// crc generator polynomials without the top term
`define SCF_POLY10 10'h24f
`define SCF_POLY8 8'h4d
`endif

// *** design/scf_fifo.v ***
`timescale 1ns/1ps
// show-ahead fifo, registered ready and valid
module scf_fifo #(
  parameter WIDTH = 51,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // sized copies of the depth so pointer and count compares keep their widths
  localparam [31:0] LAST = DEPTH - 1;
  localparam [31:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  wire push;
  wire pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  // occupancy after this cycle
  always @*
  begin
    count_next = count_reg;
    if (push & ~pop)
      count_next = count_reg + 1'b1;
    else if (pop & ~push)
      count_next = count_reg - 1'b1;
  end

  // storage write
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // pointers and flags
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == LAST[AW-1:0]) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == LAST[AW-1:0]) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      in_ready <= (count_next != FULL[AW:0]); // full stalls the source
      out_valid <= (count_next != {(AW+1){1'b0}});
    end
  end
endmodule

// *** design/scf_framer.v ***
// Overview of operation
// - idle sync slots carry a classification code
// - black and image codes from registers
// - crc and training codes, full words
// - 8-bit codes use register bits 9:2
// - 8-bit sync drops marker low bits
// - 8-bit type code in bits 7:5
// - 8-bit window id in bits 4:2
// - idle lanes train, sync sends training code
// - 10-bit lane training is full register
// - 8-bit lane training uses bits 9:2
// - each lane sends line crc at end
// - sync lane marks crc slots only
// - 10-bit crc polynomial x10+x9+x6+x3+x2+x+1
// - crc seeded per line, zeros or ones
// - 8-bit crc polynomial x8+x6+x3+x2+1
// - crc spans whole physical line
// - kernels of eight pixels, bottom-left first
// - 10-bit type bits 9:7, marker 6:0
// - 10-bit window id follows, highest wins
// - lines open and close, frame ends replace
`timescale 1ns/1ps
`include "scf_defs.vh"
module scf_framer #(
  parameter LANES = 4,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire core_clk,
  input wire rst_b,
  input wire pix_clk_in,
  input wire up_valid,
  output wire up_ready,
  input wire [1:0] up_kind,
  input wire up_edge,
  input wire [7:0] up_win_mask,
  input wire [LANES*10-1:0] up_lanes,
  input wire cfg_wr,
  input wire [7:0] cfg_addr,
  input wire [9:0] cfg_wdata,
  output reg [9:0] cfg_rdata,
  output reg [9:0] sync_word_out,
  output reg [LANES*10-1:0] lane_word_out,
  output reg word_stb_out
);
  localparam EW = 2 + 1 + 8 + LANES * 10;
  // one-hot states
  localparam [3:0] S_RUN = 4'b0001;
  localparam [3:0] S_ID = 4'b0010;
  localparam [3:0] S_CRC = 4'b0100;
  localparam [3:0] S_CLS = 4'b1000;

  reg [9:0] dtrain_reg;
  reg [6:0] marker_reg;
  reg [9:0] black_reg;
  reg [9:0] image_reg;
  reg [9:0] crcind_reg;
  reg [9:0] strain_reg;
  reg [1:0] ctrl_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg pclk_s1_reg;
  reg pclk_s2_reg;
  reg pclk_s3_reg;
  reg [2:0] win_reg;
  reg [2:0] win_next;
  reg edge_reg;
  reg edge_next;
  reg [9:0] sync_next;
  reg [LANES*10-1:0] lane_next;
  reg pop;
  reg crc_seed_now;
  reg crc_upd_now;
  reg [LANES*10-1:0] crc_reg;
  wire [LANES*10-1:0] crc_step;
  wire [LANES*10-1:0] crc_view;
  wire [LANES*10-1:0] dtrain_all;
  wire slot_en;
  wire mode8;
  wire [9:0] seed;
  wire f_valid;
  wire [EW-1:0] f_data;
  wire [1:0] f_kind;
  wire f_edge;
  wire [7:0] f_mask;
  wire [LANES*10-1:0] f_lanes;
  wire [9:0] cls_black;
  wire [9:0] cls_image;
  wire [9:0] cls_crc;
  wire [9:0] cls_train;
  wire [9:0] dtrain_w;

  assign mode8 = ctrl_reg[`SCF_CTL_MODE8];
  // seed select
  // seed zeros or ones
  assign seed = ctrl_reg[`SCF_CTL_SEED] ? 10'h3ff : 10'h000;

  // crc update for one lane word, serial msb first
  function [9:0] crc_word;
    input [9:0] c;
    input [9:0] d;
    input m8;
    integer i;
    reg [9:0] r;
    reg fb;
    begin
      r = c;
      fb = 1'b0;
      if (m8)
      begin
        for (i = 7; i >= 0; i = i - 1)
        begin
          fb = r[7] ^ d[i];
          r[7:0] = {r[6:0], 1'b0} ^ (fb ? `SCF_POLY8 : 8'h00);
        end
        r[9:8] = 2'b00;
      end
      else
      begin
        for (i = 9; i >= 0; i = i - 1)
        begin
          fb = r[9] ^ d[i];
          r = {r[8:0], 1'b0} ^ (fb ? `SCF_POLY10 : 10'h000);
        end
      end
      crc_word = r;
    end
  endfunction

  // highest set bit of the window mask
  function [2:0] top_win;
    input [7:0] m;
    integer i;
    begin
      top_win = 3'h0;
      for (i = 0; i < 8; i = i + 1)
        if (m[i])
          top_win = i[2:0];
    end
  endfunction

  // frame sync word, type on top, marker below
  function [9:0] sync_word;
    input [2:0] t;
    input [6:0] mk;
    input m8;
    begin
      if (m8)
        sync_word = {2'b00, t, mk[6:2]};
      else
        sync_word = {t, mk};
    end
  endfunction

  // link clock synchroniser and rising edge as word slot enable
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pclk_s1_reg <= 1'b0;
      pclk_s2_reg <= 1'b0;
      pclk_s3_reg <= 1'b0;
    end
    else
    begin
      pclk_s1_reg <= pix_clk_in;
      pclk_s2_reg <= pclk_s1_reg;
      pclk_s3_reg <= pclk_s2_reg;
    end
  end
  assign slot_en = pclk_s2_reg & ~pclk_s3_reg;

  // stream entries wait here until their word slot
  scf_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(core_clk),
    .rst_b(rst_b),
    .in_valid(up_valid),
    .in_ready(up_ready),
    .in_data({up_kind, up_edge, up_win_mask, up_lanes}),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );
  assign f_kind = f_data[EW-1:EW-2];
  assign f_edge = f_data[EW-3];
  assign f_mask = f_data[EW-4:EW-11];
  assign f_lanes = f_data[LANES*10-1:0];

  // classification codes per word mode
  // black, image, crc mark and training codes
  assign cls_black = mode8 ? {2'b00, black_reg[9:2]} : black_reg;
  assign cls_image = mode8 ? {2'b00, image_reg[9:2]} : image_reg;
  assign cls_crc = mode8 ? {2'b00, crcind_reg[9:2]} : crcind_reg;
  assign cls_train = mode8 ? {2'b00, strain_reg[9:2]} : strain_reg;
  assign dtrain_w = mode8 ? {2'b00, dtrain_reg[9:2]} : dtrain_reg;

  // per-lane crc engines
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_lane
      assign crc_step[g*10 +: 10] =
        crc_word(crc_reg[g*10 +: 10], f_lanes[g*10 +: 10], mode8);
      assign crc_view[g*10 +: 10] =
        mode8 ? {2'b00, crc_reg[g*10 +: 8]} : crc_reg[g*10 +: 10];
      assign dtrain_all[g*10 +: 10] = dtrain_w;
    end
  endgenerate

  // slot sequencer: what the sync and data lanes carry next
  always @*
  begin
    state_next = state_reg;
    win_next = win_reg;
    edge_next = edge_reg;
    sync_next = cls_train;
    lane_next = dtrain_all;
    pop = 1'b0;
    crc_seed_now = 1'b0;
    crc_upd_now = 1'b0;
    case (state_reg)
      S_RUN:
      begin
        if (slot_en & f_valid)
        begin
          pop = 1'b1;
          case (f_kind)
            `SCF_KIND_OPEN:
            begin
              sync_next = sync_word(f_edge ? `SCF_TYPE_FOPEN : `SCF_TYPE_LOPEN,
                marker_reg, mode8);
              win_next = top_win(f_mask);
              crc_seed_now = 1'b1;
              state_next = S_ID;
            end
            `SCF_KIND_CLOSE:
            begin
              edge_next = f_edge;
              win_next = top_win(f_mask);
              // crc goes out at line end
              sync_next = cls_crc;
              lane_next = crc_view;
              state_next = S_CLS;
            end
            default:
            begin
              // code in the same slot as data
              sync_next = (f_kind == `SCF_KIND_IMAGE) ? cls_image : cls_black;
              lane_next = f_lanes;
              crc_upd_now = 1'b1;
            end
          endcase
        end
        else if (slot_en)
        begin
          sync_next = cls_train;
          lane_next = dtrain_all;
        end
      end
      S_CLS:
      begin
        if (slot_en)
        begin
          sync_next = sync_word(edge_reg ? `SCF_TYPE_FCLOSE : `SCF_TYPE_LCLOSE,
            marker_reg, mode8);
          state_next = S_ID;
        end
      end
      S_ID:
      begin
        if (slot_en)
        begin
          sync_next = mode8 ? {5'h00, win_reg, 2'b00} : {7'h00, win_reg};
          state_next = S_RUN;
        end
      end
      default:
        state_next = S_RUN;
    endcase
  end

  // sequencer state, crc and output words
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= S_RUN;
      win_reg <= 3'h0;
      edge_reg <= 1'b0;
      crc_reg <= {(LANES*10){1'b0}};
      sync_word_out <= `SCF_RST_STRAIN;
      lane_word_out <= {LANES{`SCF_RST_DTRAIN}};
      word_stb_out <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      win_reg <= win_next;
      edge_reg <= edge_next;
      word_stb_out <= slot_en;
      if (crc_seed_now)
        crc_reg <= {LANES{seed}};
      else if (crc_upd_now)
        crc_reg <= crc_step;
      if (slot_en)
      begin
        sync_word_out <= sync_next;
        lane_word_out <= lane_next;
      end
    end
  end

  // configuration writes
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dtrain_reg <= `SCF_RST_DTRAIN;
      marker_reg <= `SCF_RST_MARKER;
      black_reg <= `SCF_RST_BLACK;
      image_reg <= `SCF_RST_IMAGE;
      crcind_reg <= `SCF_RST_CRCIND;
      strain_reg <= `SCF_RST_STRAIN;
      ctrl_reg <= `SCF_RST_CTRL;
    end
    else if (cfg_wr)
    begin
      case (cfg_addr)
        `SCF_ADDR_DTRAIN: dtrain_reg <= cfg_wdata;
        `SCF_ADDR_MARKER: marker_reg <= cfg_wdata[6:0];
        `SCF_ADDR_BLACK: black_reg <= cfg_wdata;
        `SCF_ADDR_IMAGE: image_reg <= cfg_wdata;
        `SCF_ADDR_CRCIND: crcind_reg <= cfg_wdata;
        `SCF_ADDR_STRAIN: strain_reg <= cfg_wdata;
        `SCF_ADDR_CTRL: ctrl_reg <= cfg_wdata[1:0];
        default: ctrl_reg <= ctrl_reg; // unmapped writes dropped
      endcase
    end
  end

  // registered read-back, unmapped reads zero
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_rdata <= 10'h000;
    else
    begin
      case (cfg_addr)
        `SCF_ADDR_DTRAIN: cfg_rdata <= dtrain_reg;
        `SCF_ADDR_MARKER: cfg_rdata <= {3'h0, marker_reg};
        `SCF_ADDR_BLACK: cfg_rdata <= black_reg;
        `SCF_ADDR_IMAGE: cfg_rdata <= image_reg;
        `SCF_ADDR_CRCIND: cfg_rdata <= crcind_reg;
        `SCF_ADDR_STRAIN: cfg_rdata <= strain_reg;
        `SCF_ADDR_CTRL: cfg_rdata <= {8'h00, ctrl_reg};
        `SCF_ADDR_STATUS: cfg_rdata <= {2'b00, f_valid, win_reg, state_reg};
        default: cfg_rdata <= 10'h000;
      endcase
    end
  end
endmodule

// *** verif/scf_framer_checker.sv ***
`timescale 1ns/1ps
// watches slot timing, the register port and sync word framing
module scf_framer_checker #(
  parameter LANES = 4
) (
  input wire core_clk,
  input wire rst_b,
  input wire cfg_wr,
  input wire [7:0] cfg_addr,
  input wire [9:0] cfg_wdata,
  input wire [9:0] cfg_rdata,
  input wire [9:0] sync_word_out,
  input wire [LANES*10-1:0] lane_word_out,
  input wire word_stb_out
);
  reg mode8_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // mirror of the 8-bit mode control bit
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      mode8_reg <= 1'b0;
    else if (cfg_wr && cfg_addr == 8'h88)
      mode8_reg <= cfg_wdata[0];
  a_stb_pulse: assert property (word_stb_out |=> !word_stb_out)
    else $error("slot strobe longer than one cycle");
  a_stb_spacing: assert property ($rose(word_stb_out) |=> (!word_stb_out)[*8])
    else $error("slot strobes too close");
  a_words_stand: assert property (!word_stb_out |->
    $stable(sync_word_out) && $stable(lane_word_out)) else $error("words moved between slots");
  a_mode8_top: assert property (word_stb_out && mode8_reg |-> sync_word_out[9:8] == 2'b00)
    else $error("8-bit sync word has high bits set");
  a_rdata_follow: assert property ((cfg_wr && cfg_addr == 8'h84) ##1
    (!cfg_wr && cfg_addr == 8'h84) |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("black code readback wrong");
  a_unmapped_zero: assert property (cfg_addr == 8'h80 |=> cfg_rdata == 10'h000)
    else $error("unmapped read not zero");
  a_id_follows: assert property (word_stb_out && !mode8_reg && sync_word_out[6:0] == 7'h2a
    |-> ##[24:26] (word_stb_out && sync_word_out[9:3] == 7'h00))
    else $error("window id missing after sync code");
  a_crc_close: assert property (word_stb_out && !mode8_reg && sync_word_out == 10'h059
    |-> ##[24:26] (word_stb_out && sync_word_out[9:7] inside {3'h2, 3'h6}))
    else $error("crc slot not followed by close code");
endmodule

// *** verif/scf_rx_model.sv ***
`timescale 1ns/1ps
// receiving end: makes the word clock and records every slot
module scf_rx_model (
  input wire core_clk,
  output reg pix_clk_in,
  input wire word_stb_out,
  input wire [9:0] sync_word_out,
  input wire [39:0] lane_word_out
);
  reg [9:0] rx_sync [0:255];
  reg [39:0] rx_lane [0:255];
  integer rx_n = 0;
  // free running word clock, phase unrelated to core_clk
  initial
  begin
    pix_clk_in = 1'b0;
    #37.3;
    forever #62.5 pix_clk_in = ~pix_clk_in;
  end
  always @(posedge core_clk)
    if (word_stb_out)
    begin
      rx_sync[rx_n[7:0]] <= sync_word_out;
      rx_lane[rx_n[7:0]] <= lane_word_out;
      rx_n <= rx_n + 1;
    end
endmodule

// *** verif/scf_framer_tb.sv ***
`timescale 1ns/1ps
module scf_framer_tb;
  reg core_clk = 1'b0, rst_b = 1'b0, up_valid = 1'b0, up_edge = 1'b0, cfg_wr = 1'b0;
  reg [1:0] up_kind = 2'h0;
  reg [7:0] up_win_mask = 8'h00, cfg_addr = 8'h00, msk;
  reg [39:0] up_lanes = 40'h0, lanes;
  reg [9:0] cfg_wdata = 10'h000, px, e_open, e_id, e_cls, trn;
  reg m8, sd, ed, saw_full;
  reg [1:0] knd;
  wire up_ready, word_stb_out, pix_clk_in;
  wire [9:0] cfg_rdata, sync_word_out;
  wire [39:0] lane_word_out;
  integer n_errors = 0, comparisons = 0, i, k, r, t, base;
  // rows: mode8, seed, edge, mask, kind, pixel, open, id, class
  reg [52:0] rows [0:3] = '{{3'b001, 8'h03, 2'h1, 10'h155, 10'h2aa, 10'h001, 10'h035},
    {3'b010, 8'h84, 2'h0, 10'h2c3, 10'h0aa, 10'h007, 10'h015},
    {3'b101, 8'h24, 2'h1, 10'h05a, 10'h0aa, 10'h014, 10'h00d},
    {3'b110, 8'h01, 2'h0, 10'h0c3, 10'h02a, 10'h000, 10'h005}};
  localparam [69:0] RV = {10'h000, 10'h3a6, 10'h059, 10'h035, 10'h015, 10'h02a, 10'h3a6};
  scf_framer dut_u (.core_clk(core_clk), .rst_b(rst_b), .pix_clk_in(pix_clk_in),
    .up_valid(up_valid), .up_ready(up_ready), .up_kind(up_kind), .up_edge(up_edge),
    .up_win_mask(up_win_mask), .up_lanes(up_lanes), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .sync_word_out(sync_word_out),
    .lane_word_out(lane_word_out), .word_stb_out(word_stb_out));
  scf_rx_model rx_u (.core_clk(core_clk), .pix_clk_in(pix_clk_in), .word_stb_out(word_stb_out),
    .sync_word_out(sync_word_out), .lane_word_out(lane_word_out));
  // 200 MHz core clock
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task end_of_test;
    begin
      if (n_errors == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [39:0] exp, input [39:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task bump;
    begin
      t = t + 1;
      if (t > 2000)
      begin
        n_errors = n_errors + 1;
        end_of_test;
      end
    end
  endtask
  task wr(input [7:0] a, input [9:0] d);
    begin
      @(posedge core_clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge core_clk);
      cfg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [9:0] exp);
    begin
      @(posedge core_clk);
      cfg_addr <= a;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("cfg_rdata", exp, cfg_rdata);
    end
  endtask
  // hold the entry until the fifo takes it
  task push(input [1:0] kd, input e, input [7:0] m, input [39:0] l);
    begin
      up_valid <= 1'b1;
      up_kind <= kd;
      up_edge <= e;
      up_win_mask <= m;
      up_lanes <= l;
      t = 0;
      @(negedge core_clk);
      while (up_ready !== 1'b1)
      begin
        saw_full = 1'b1;
        bump;
        @(negedge core_clk);
      end
      @(posedge core_clk);
    end
  endtask
  task wait_slots(input integer n);
    begin
      t = 0;
      up_valid <= 1'b0;
      while (rx_u.rx_n < base + n)
      begin
        bump;
        @(negedge core_clk);
      end
      k = base;
      while (rx_u.rx_sync[k] === trn && k < base + 3)
        k = k + 1;
    end
  endtask
  task wait_stb;
    begin
      t = 0;
      @(negedge core_clk);
      while (word_stb_out !== 1'b1)
      begin
        bump;
        @(negedge core_clk);
      end
    end
  endtask
  // serial msb-first crc over one lane word
  function [9:0] crc_of(input m, input s, input [9:0] d);
    reg [9:0] c;
    integer j;
    begin
      c = s ? (m ? 10'h0ff : 10'h3ff) : 10'h000;
      for (j = 9; j >= 0; j = j - 1)
        if (!m || j < 8)
          c = ((c << 1) ^ (((m ? c[7] : c[9]) ^ d[j]) ? (m ? 10'h04d : 10'h24f) : 10'h0)) &
            (m ? 10'h0ff : 10'h3ff);
      crc_of = c;
    end
  endfunction
  initial
  begin
    repeat (2) @(posedge core_clk);
    chk("reset sync", 10'h3a6, sync_word_out);
    chk("reset ready", 1'b0, up_ready);
    rst_b <= 1'b1;
    for (i = 0; i < 7; i = i + 1)
      rd(8'h82 + i[7:0], RV[i*10+:10]);
    wr(8'h84, 10'h155);
    rd(8'h84, 10'h155);
    wr(8'h84, 10'h015);
    wr(8'h80, 10'h3ff);
    rd(8'h80, 10'h000);
    // one line per row
    for (r = 0; r < 4; r = r + 1)
    begin
      {m8, sd, ed, msk, knd, px, e_open, e_id, e_cls} = rows[r];
      wait_stb;
      wr(8'h88, {8'h00, sd, m8});
      trn = m8 ? 10'h0e9 : 10'h3a6;
      lanes = {px + 10'h033, px + 10'h022, px + 10'h011, px};
      base = rx_u.rx_n;
      push(2'h2, ed, msk, 40'h0);
      push(knd, 1'b0, 8'h00, lanes);
      push(2'h3, ed, msk, 40'h0);
      wait_slots(10);
      chk("open", e_open, rx_u.rx_sync[k]);
      chk("train lanes", {4{trn}}, rx_u.rx_lane[k]);
      chk("id", e_id, rx_u.rx_sync[k+1]);
      chk("class", e_cls, rx_u.rx_sync[k+2]);
      chk("pixels", lanes, rx_u.rx_lane[k+2]);
      chk("crc mark", m8 ? 10'h016 : 10'h059, rx_u.rx_sync[k+3]);
      for (i = 0; i < 4; i = i + 1)
        chk("crc", crc_of(m8, sd, lanes[i*10+:10]), rx_u.rx_lane[k+3][i*10+:10]);
      chk("close", m8 ? {2'b0, ed ? 3'h6 : 3'h2, 5'h0a} : {ed ? 3'h6 : 3'h2, 7'h2a}, rx_u.rx_sync[k+4]);
      chk("close id", e_id, rx_u.rx_sync[k+5]);
      chk("idle", trn, rx_u.rx_sync[k+6]);
    end
    // programmed marker and lane training in 8-bit mode
    wait_stb;
    wr(8'h83, 10'h057);
    wr(8'h82, 10'h2f1);
    base = rx_u.rx_n;
    push(2'h2, 1'b1, 8'h40, 40'h0);
    push(2'h3, 1'b1, 8'h40, 40'h0);
    wait_slots(9);
    chk("marker", 10'h0b5, rx_u.rx_sync[k]);
    chk("lane train", {4{10'h0bc}}, rx_u.rx_lane[k]);
    chk("id", 10'h018, rx_u.rx_sync[k+1]);
    chk("idle sync", 10'h0e9, rx_u.rx_sync[k+5]);
    // overfill the fifo, nothing may be lost
    wait_stb;
    wr(8'h88, 10'h000);
    trn = 10'h3a6;
    saw_full = 1'b0;
    base = rx_u.rx_n;
    push(2'h2, 1'b0, 8'h01, 40'h0);
    for (i = 0; i < 18; i = i + 1)
      push(2'h1, 1'b0, 8'h00, {4{i[9:0]}});
    push(2'h3, 1'b0, 8'h01, 40'h0);
    chk("fifo full", 1'b1, saw_full);
    wait_slots(28);
    r = 0;
    for (i = 0; i < 28; i = i + 1)
      r = r + (rx_u.rx_sync[base+i] === 10'h035);
    chk("image slots", 18, r);
    // mid-run reset puts words and registers back to defaults
    wr(8'h84, 10'h0f0);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("reset lanes", {4{10'h3a6}}, lane_word_out);
    chk("reset strobe", 1'b0, word_stb_out);
    chk("reset rdata", 10'h000, cfg_rdata);
    chk("reset ready", 1'b0, up_ready);
    rst_b <= 1'b1;
    rd(8'h84, 10'h015);
    rd(8'h88, 10'h000);
    end_of_test;
  end
endmodule
bind scf_framer scf_framer_checker #(.LANES(LANES)) chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .sync_word_out(sync_word_out), .lane_word_out(lane_word_out), .word_stb_out(word_stb_out));
